// ==== src/sme_pkg.sv ====
package sme_pkg;
    // ---------------------------------------------------------------
    // register map (byte addresses, one 32-bit word each)
    // ---------------------------------------------------------------
    localparam logic [7:0] SME_OFF_CTRL = 8'h00;
    localparam logic [7:0] SME_OFF_SPEED = 8'h04;
    localparam logic [7:0] SME_OFF_CMD = 8'h08;
    localparam logic [7:0] SME_OFF_TXDATA = 8'h0C;
    localparam logic [7:0] SME_OFF_RXDATA = 8'h10;
    localparam logic [7:0] SME_OFF_STATUS = 8'h14;
    // ---------------------------------------------------------------
    // field positions
    // ---------------------------------------------------------------
    localparam int SME_CTRL_OPEN_BIT = 0;
    localparam int SME_CTRL_MODE_LSB = 1;
    localparam int SME_CTRL_WSEL_LSB = 3;
    localparam int SME_CMD_CNT_LSB = 0;
    localparam int SME_CMD_OP_LSB = 16;
    localparam int SME_STAT_BUSY_BIT = 0;
    localparam int SME_STAT_DONE_BIT = 1;
    localparam int SME_STAT_OPEN_BIT = 2;
    localparam int SME_STAT_TXLVL_LSB = 8;
    localparam int SME_STAT_RXLVL_LSB = 16;
    // ---------------------------------------------------------------
    // reset values and timing
    // ---------------------------------------------------------------
    localparam logic [31:0] SME_SPEED_RST = 32'h000F4240;
    localparam int unsigned SME_CLK_HZ = 200000000;
    localparam int unsigned SME_SCLK_DIV_MIN = 4;
    localparam int SME_FIFO_DEPTH = 32;
    // ---------------------------------------------------------------
    // enumerations
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        SME_OP_SINGLE = 2'h0,
        SME_OP_BULK_WRITE = 2'h1,
        SME_OP_BULK_READ = 2'h2
    } sme_op_t;
    typedef enum logic [1:0] {
        SME_WSEL_8 = 2'h0,
        SME_WSEL_16 = 2'h1,
        SME_WSEL_32 = 2'h2
    } sme_wsel_t;
    typedef enum logic [2:0] {
        SME_ST_IDLE = 3'h1,
        SME_ST_LOAD = 3'h2,
        SME_ST_SHIFT = 3'h4
    } sme_fsm_t;
endpackage

// ==== src/sme_top.sv ====
`timescale 1ns/100ps
`default_nettype none

module sme_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = sme_pkg::SME_FIFO_DEPTH
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // filling side
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // draining side
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData,
    output logic [$clog2(DEPTH+1)-1:0] level
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);

    if (DEPTH < 2 || (1 << PW) != DEPTH || WIDTH < 1) begin : g_check
        $error("sme_fifo: DEPTH must be a power of two >= 2");
    end

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] wr;
        logic [PW-1:0] rd;
        logic [CW-1:0] cnt;
    } sme_fifo_state_t;

    sme_fifo_state_t st_reg;
    sme_fifo_state_t st_next;
    logic push;
    logic pop;

    assign inReady = st_reg.cnt != CW'(DEPTH);
    assign outValid = st_reg.cnt != '0;
    assign outData = st_reg.mem[st_reg.rd];
    assign level = st_reg.cnt;
    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    always_comb begin
        st_next = st_reg;
        if (push) begin
            st_next.mem[st_reg.wr] = inData;
            st_next.wr = st_reg.wr + 1'b1;
        end
        if (pop) begin
            st_next.rd = st_reg.rd + 1'b1;
        end
        if (push && !pop) begin
            st_next.cnt = st_reg.cnt + 1'b1;
        end else if (pop && !push) begin
            st_next.cnt = st_reg.cnt - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
endmodule

// Summary of operation
// - always master; serial clock generated internally
// - open: master-in input, master-out driven
// - close: release clock and data pins
// - requested Hz clamped to clock quarter
// - word width 8, 16 or 32
// - most significant bit first both ways
// - mode 0: idle low, sample rising
// - mode 1: idle low, sample falling
// - mode 2: idle high, sample falling
// - mode 3: idle high, sample rising
// - single word full duplex, received word returned
// - bulk write sends count words in order
// - bulk write discards received words
// - bulk read sends zeros, stores received words
module sme_top #(
    parameter int unsigned CLK_HZ = sme_pkg::SME_CLK_HZ,
    parameter int FIFO_DEPTH = sme_pkg::SME_FIFO_DEPTH
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // spi pins
    output logic sclk,
    output logic sclkOe,
    output logic mosi,
    output logic mosiOe,
    input wire logic misoIn,
    output logic misoOe,
    // status
    output logic busy
);
    import sme_pkg::*;

    localparam logic [31:0] CLK_HZ32 = 32'(CLK_HZ);
    localparam logic [31:0] SPEED_MAX = 32'(CLK_HZ / SME_SCLK_DIV_MIN);
    localparam int LW = $clog2(FIFO_DEPTH+1);

    if (CLK_HZ < SME_SCLK_DIV_MIN || CLK_HZ > 32'h7FFFFFFF || LW > 8) begin : g_check
        $error("sme_top: CLK_HZ or FIFO_DEPTH out of range");
    end

    typedef struct packed {
        sme_fsm_t fsm;
        logic open;
        logic [1:0] mode;
        sme_wsel_t wsel;
        logic [31:0] speed;
        sme_op_t op;
        logic [15:0] remain;
        logic [31:0] acc;
        logic [6:0] edgeCnt;
        logic [31:0] txSh;
        logic [31:0] rxSh;
        logic done;
        logic busy;
        logic sclk;
        logic sclkOe;
        logic mosi;
        logic mosiOe;
        logic misoOe;
        logic misoMeta;
        logic misoSync;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } sme_state_t;

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    function automatic logic [6:0] lastEdge(input sme_wsel_t w);
        case (w)
            SME_WSEL_8: lastEdge = 7'h0F;
            SME_WSEL_16: lastEdge = 7'h1F;
            default: lastEdge = 7'h3F;
        endcase
    endfunction

    function automatic logic [31:0] alignWord(input logic [31:0] d, input sme_wsel_t w);
        case (w)
            SME_WSEL_8: alignWord = {d[7:0], 24'h000000};
            SME_WSEL_16: alignWord = {d[15:0], 16'h0000};
            default: alignWord = d;
        endcase
    endfunction

    function automatic logic [31:0] maskWord(input logic [31:0] d, input sme_wsel_t w);
        case (w)
            SME_WSEL_8: maskWord = {24'h000000, d[7:0]};
            SME_WSEL_16: maskWord = {16'h0000, d[15:0]};
            default: maskWord = d;
        endcase
    endfunction

    // ---------------------------------------------------------------
    // buffers
    // ---------------------------------------------------------------
    sme_state_t st_reg;
    sme_state_t st_next;
    logic txPush;
    logic txInReady;
    logic txOutValid;
    logic txPop;
    logic [31:0] txOutData;
    logic [LW-1:0] txLevel;
    logic rxPush;
    logic [31:0] rxPushData;
    logic rxInReady;
    logic rxOutValid;
    logic rxPop;
    logic [31:0] rxOutData;
    logic [LW-1:0] rxLevel;

    sme_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) u_txFifo (
        .clk(clk),
        .resetn(resetn),
        .inValid(txPush),
        .inReady(txInReady),
        .inData(pwdata),
        .outValid(txOutValid),
        .outReady(txPop),
        .outData(txOutData),
        .level(txLevel)
    );

    sme_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) u_rxFifo (
        .clk(clk),
        .resetn(resetn),
        .inValid(rxPush),
        .inReady(rxInReady),
        .inData(rxPushData),
        .outValid(rxOutValid),
        .outReady(rxPop),
        .outData(rxOutData),
        .level(rxLevel)
    );

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        logic access;
        logic commit;
        logic [31:0] sum;
        logic tick;
        logic lead;
        logic needTx;
        logic needRx;
        logic [31:0] word;
        logic [31:0] rxNew;
        access = 1'b0;
        commit = 1'b0;
        sum = '0;
        tick = 1'b0;
        lead = 1'b0;
        needTx = 1'b0;
        needRx = 1'b0;
        word = '0;
        rxNew = '0;
        st_next = st_reg;
        txPush = 1'b0;
        txPop = 1'b0;
        rxPush = 1'b0;
        rxPop = 1'b0;
        rxPushData = '0;
        // slow input crosses two flops before use
        st_next.misoMeta = misoIn;
        st_next.misoSync = st_reg.misoMeta;

        // apb: prepare answer in first access cycle, act at the completing edge
        access = psel && penable;
        commit = access && st_reg.pready;
        if (access && !st_reg.pready) begin
            st_next.pready = 1'b1;
            st_next.pslverr = 1'b0;
            st_next.prdata = '0;
            case (paddr)
                SME_OFF_CTRL: begin
                    st_next.prdata[SME_CTRL_OPEN_BIT] = st_reg.open;
                    st_next.prdata[SME_CTRL_MODE_LSB +: 2] = st_reg.mode;
                    st_next.prdata[SME_CTRL_WSEL_LSB +: 2] = st_reg.wsel;
                    if (pwrite && (st_reg.busy || pwdata[SME_CTRL_WSEL_LSB +: 2] == 2'h3)) begin
                        st_next.pslverr = 1'b1;
                    end
                end
                SME_OFF_SPEED: begin
                    st_next.prdata = st_reg.speed;
                    st_next.pslverr = pwrite && st_reg.busy;
                end
                SME_OFF_CMD: begin
                    if (pwrite && (st_reg.busy || !st_reg.open
                        || pwdata[SME_CMD_OP_LSB +: 2] == 2'h3
                        || pwdata[SME_CMD_CNT_LSB +: 16] == 16'h0000)) begin
                        st_next.pslverr = 1'b1;
                    end
                end
                SME_OFF_TXDATA: begin
                    // full buffer stalls the bus rather than losing a word
                    st_next.pready = !pwrite || txInReady;
                end
                SME_OFF_RXDATA: begin
                    st_next.prdata = rxOutValid ? rxOutData : '0;
                    st_next.pslverr = pwrite || !rxOutValid;
                end
                SME_OFF_STATUS: begin
                    st_next.prdata[SME_STAT_BUSY_BIT] = st_reg.busy;
                    st_next.prdata[SME_STAT_DONE_BIT] = st_reg.done;
                    st_next.prdata[SME_STAT_OPEN_BIT] = st_reg.open;
                    st_next.prdata[SME_STAT_TXLVL_LSB +: LW] = txLevel;
                    st_next.prdata[SME_STAT_RXLVL_LSB +: LW] = rxLevel;
                end
                default: begin
                    st_next.pslverr = 1'b1;
                end
            endcase
        end
        if (commit) begin
            // error flag stands only with its ready pulse
            st_next.pready = 1'b0;
            st_next.pslverr = 1'b0;
            if (!st_reg.pslverr) begin
                case (paddr)
                    SME_OFF_CTRL: begin
                        if (pwrite) begin
                            st_next.open = pwdata[SME_CTRL_OPEN_BIT];
                            st_next.mode = pwdata[SME_CTRL_MODE_LSB +: 2];
                            st_next.wsel = sme_wsel_t'(pwdata[SME_CTRL_WSEL_LSB +: 2]);
                            st_next.sclkOe = pwdata[SME_CTRL_OPEN_BIT];
                            st_next.mosiOe = pwdata[SME_CTRL_OPEN_BIT];
                            st_next.sclk = pwdata[SME_CTRL_MODE_LSB + 1];
                            if (!pwdata[SME_CTRL_OPEN_BIT]) begin
                                st_next.mosi = 1'b0;
                            end
                        end
                    end
                    SME_OFF_SPEED: begin
                        if (pwrite) begin
                            st_next.speed = (pwdata > SPEED_MAX) ? SPEED_MAX : pwdata;
                        end
                    end
                    SME_OFF_CMD: begin
                        if (pwrite) begin
                            st_next.op = sme_op_t'(pwdata[SME_CMD_OP_LSB +: 2]);
                            st_next.remain = (pwdata[SME_CMD_OP_LSB +: 2] == SME_OP_SINGLE)
                                ? 16'h0001 : pwdata[SME_CMD_CNT_LSB +: 16];
                            st_next.busy = 1'b1;
                            st_next.fsm = SME_ST_LOAD;
                        end
                    end
                    SME_OFF_TXDATA: begin
                        txPush = pwrite;
                    end
                    SME_OFF_RXDATA: begin
                        rxPop = 1'b1;
                    end
                    SME_OFF_STATUS: begin
                        if (pwrite && pwdata[SME_STAT_DONE_BIT]) begin
                            st_next.done = 1'b0;
                        end
                    end
                    default: begin
                        st_next.pready = 1'b0;
                    end
                endcase
            end
        end

        // ---------------------------------------------------------------
        // shift engine
        // ---------------------------------------------------------------
        // phase accumulator avoids a divider: two edges per requested period
        sum = st_reg.acc + {st_reg.speed[30:0], 1'b0};
        tick = sum >= CLK_HZ32;
        lead = !st_reg.edgeCnt[0];
        needTx = st_reg.op != SME_OP_BULK_READ;
        needRx = st_reg.op != SME_OP_BULK_WRITE;
        case (st_reg.fsm)
            SME_ST_IDLE: begin
                st_next.acc = '0;
            end
            SME_ST_LOAD: begin
                // wait for a word to send and room for the answer
                if ((!needTx || txOutValid) && (!needRx || rxInReady)) begin
                    txPop = needTx;
                    word = needTx ? txOutData : '0;
                    word = alignWord(word, st_reg.wsel);
                    st_next.acc = '0;
                    st_next.edgeCnt = '0;
                    st_next.rxSh = '0;
                    st_next.txSh = word;
                    if (!st_reg.mode[0]) begin
                        st_next.mosi = word[31];
                        st_next.txSh = {word[30:0], 1'b0};
                    end
                    st_next.fsm = SME_ST_SHIFT;
                end
            end
            SME_ST_SHIFT: begin
                st_next.acc = tick ? sum - CLK_HZ32 : sum;
                if (tick) begin
                    st_next.sclk = !st_reg.sclk;
                    st_next.edgeCnt = st_reg.edgeCnt + 7'h01;
                    rxNew = st_reg.rxSh;
                    // leading edge samples when phase is 0, trailing when 1
                    if (lead ^ st_reg.mode[0]) begin
                        rxNew = {st_reg.rxSh[30:0], st_reg.misoSync};
                    end
                    st_next.rxSh = rxNew;
                    if (st_reg.mode[0] ? lead : (!lead && st_reg.edgeCnt != lastEdge(st_reg.wsel))) begin
                        st_next.mosi = st_reg.txSh[31];
                        st_next.txSh = {st_reg.txSh[30:0], 1'b0};
                    end
                    if (st_reg.edgeCnt == lastEdge(st_reg.wsel)) begin
                        rxPush = needRx;
                        rxPushData = maskWord(rxNew, st_reg.wsel);
                        st_next.remain = st_reg.remain - 16'h0001;
                        if (st_reg.remain == 16'h0001) begin
                            st_next.fsm = SME_ST_IDLE;
                            st_next.busy = 1'b0;
                            st_next.done = 1'b1;
                        end else begin
                            st_next.fsm = SME_ST_LOAD;
                        end
                    end
                end
            end
            default: begin
                st_next.fsm = SME_ST_IDLE;
                st_next.busy = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_reg <= '0;
            st_reg.fsm <= SME_ST_IDLE;
            st_reg.speed <= SME_SPEED_RST;
            st_reg.op <= SME_OP_SINGLE;
            st_reg.wsel <= SME_WSEL_8;
        end else begin
            st_reg <= st_next;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    // master-in is never driven, so its enable is a constant-low flop
    assign prdata = st_reg.prdata;
    assign pready = st_reg.pready;
    assign pslverr = st_reg.pslverr;
    assign sclk = st_reg.sclk;
    assign sclkOe = st_reg.sclkOe;
    assign mosi = st_reg.mosi;
    assign mosiOe = st_reg.mosiOe;
    assign misoOe = st_reg.misoOe;
    assign busy = st_reg.busy;
endmodule

`default_nettype wire

// ==== tb/sme_top_monitor.sv ====
`timescale 1ns/100ps
`default_nettype none
module sme_top_monitor #(
    parameter int unsigned CLK_HZ = sme_pkg::SME_CLK_HZ,
    parameter int FIFO_DEPTH = sme_pkg::SME_FIFO_DEPTH
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // spi pins
    input wire logic sclk,
    input wire logic sclkOe,
    input wire logic mosi,
    input wire logic mosiOe,
    input wire logic misoIn,
    input wire logic misoOe,
    // status
    input wire logic busy
);
    import sme_pkg::*;
    logic ctrlWr;
    logic cmdWr;
    logic cpolReg;
    assign ctrlWr = psel && penable && pready && pwrite && !pslverr && paddr == SME_OFF_CTRL;
    assign cmdWr = psel && penable && pready && pwrite && !pslverr && paddr == SME_OFF_CMD;
    // idle level follows the last accepted control write
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cpolReg <= 1'b0;
        end else if (ctrlWr) begin
            cpolReg <= pwdata[SME_CTRL_MODE_LSB + 1];
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    a_miso_input: assert property (!misoOe) else $error("miso driven");
    a_oe_pair: assert property (sclkOe == mosiOe) else $error("enables differ");
    a_closed_quiet: assert property (!mosiOe |-> !mosi) else $error("mosi high closed");
    a_busy_open: assert property (busy |-> sclkOe && mosiOe) else $error("busy closed");
    a_quarter_rate: assert property ($changed(sclk) |=> $stable(sclk))
        else $error("sclk too fast");
    a_idle_level: assert property (!busy |-> sclk == cpolReg) else $error("idle level");
    a_sclk_when_busy: assert property ($changed(sclk) |-> $past(busy) || $past(ctrlWr))
        else $error("sclk moved idle");
    a_cmd_busy: assert property (cmdWr |=> busy) else $error("busy missing");
    a_ready_pulse: assert property (pready |=> !pready) else $error("pready long");
    a_error_ready: assert property (pslverr |-> pready && psel && penable) else $error("pslverr");
endmodule

bind sme_top sme_top_monitor #(.CLK_HZ(CLK_HZ), .FIFO_DEPTH(FIFO_DEPTH)) u_mon (
    .clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sclk(sclk),
    .sclkOe(sclkOe), .mosi(mosi), .mosiOe(mosiOe), .misoIn(misoIn), .misoOe(misoOe), .busy(busy));
`default_nettype wire

// ==== tb/sme_spi_slave.sv ====
`timescale 1ns/100ps
`default_nettype none
module sme_spi_slave (
    // system clock for the idle pattern
    input wire logic clk,
    // link pins
    input wire logic csN,
    input wire logic sclk,
    input wire logic mosi,
    output logic miso,
    // framing set by the bench
    input wire logic cpol,
    input wire logic cpha,
    input wire logic [5:0] width
);
    logic [31:0] rsp[64];
    logic [31:0] got[64];
    logic [31:0] txSh = 32'h0;
    logic [31:0] rxSh = 32'h0;
    logic idlePat = 1'b0;
    int idx;
    int nb;
    initial begin
        foreach (rsp[i]) rsp[i] = 32'hC3A50F96 ^ 32'(i);
    end
    // deselected line toggles so a stale bit can never pass as data
    always @(posedge clk) idlePat <= ~idlePat;
    assign miso = csN ? idlePat : txSh[31];
    task automatic shiftOut();
        if (nb == 0) begin
            txSh = rsp[idx] << (32 - width);
        end else begin
            txSh = txSh << 1;
        end
    endtask
    always @(negedge csN) begin
        idx = 0;
        nb = 0;
        rxSh = 32'h0;
        if (!cpha) shiftOut();
    end
    // leading edge leaves the idle level; sampling edge depends on phase
    always @(sclk) begin
        if (!csN) begin
            if ((sclk != cpol) ^ cpha) begin
                rxSh = {rxSh[30:0], mosi};
                nb++;
                if (nb == width) begin
                    got[idx] = rxSh;
                    idx++;
                    nb = 0;
                    rxSh = 32'h0;
                end
            end else begin
                shiftOut();
            end
        end
    end
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) chk(n, 32'(e), 32'(g))
module testbench;
    import sme_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rdat, tx;
    logic pready, pslverr, sclk, sclkOe, mosi, mosiOe, misoOe, busy, miso, rerr;
    logic csN = 1'b1;
    logic cpol = 1'b0;
    logic cpha = 1'b0;
    logic [5:0] width = 6'h08;
    logic [31:0] txq[$];
    int seed = 32'hBF81630D;
    int err_total = 0;
    int compares = 0;
    sme_top dut (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sclk(sclk), .sclkOe(sclkOe), .mosi(mosi), .mosiOe(mosiOe), .misoIn(miso),
        .misoOe(misoOe), .busy(busy));
    sme_spi_slave slv (.clk(clk), .csN(csN), .sclk(sclk), .mosi(mosi), .miso(miso),
        .cpol(cpol), .cpha(cpha), .width(width));
    always #2.5 clk = ~clk;
    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    function automatic logic [31:0] msk(input logic [31:0] v, input int w);
        return (w == 32) ? v : v & ((32'h1 << w) - 32'h1);
    endfunction
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic results();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // only the watchdog ends a wait for the answer
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic waitDone();
        do begin
            apb(1'b0, SME_OFF_STATUS, 32'h0);
        end while (rdat[SME_STAT_DONE_BIT] !== 1'b1);
        `CHK("busy", 1'b0, busy);
        apb(1'b1, SME_OFF_STATUS, 32'h2);
    endtask
    task automatic openCh(input int m, input int k);
        cpol = m[1];
        cpha = m[0];
        width = 6'(8 << k);
        apb(1'b1, SME_OFF_CTRL, 32'((k << 3) | (m << 1) | 1));
        @(negedge clk);
        `CHK("oe", 2'b11, {sclkOe, mosiOe});
        csN = 1'b0;
    endtask
    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    initial begin
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        apb(1'b0, SME_OFF_SPEED, 32'h0);
        `CHK("speed reset", SME_SPEED_RST, rdat);
        apb(1'b0, SME_OFF_STATUS, 32'h0);
        `CHK("status reset", 32'h0, rdat);
        apb(1'b0, 8'h18, 32'h0);
        `CHK("unmapped", 1'b1, rerr);
        apb(1'b1, SME_OFF_CMD, 32'h1);
        `CHK("cmd closed", 1'b1, rerr);
        apb(1'b1, SME_OFF_CTRL, 32'h00000018);
        `CHK("width 3", 1'b1, rerr);
        apb(1'b1, SME_OFF_SPEED, 32'h03938700);
        apb(1'b0, SME_OFF_SPEED, 32'h0);
        `CHK("speed clamp", 32'h02FAF080, rdat);
        // one sclk period of 64 ns keeps miso settled well before sampling
        apb(1'b1, SME_OFF_SPEED, 32'h00EE6B28);
        for (int m = 0; m < 4; m++) begin
            for (int k = 0; k < 3; k++) begin
                tx = $random(seed);
                slv.rsp[0] = $random(seed);
                openCh(m, k);
                apb(1'b1, SME_OFF_TXDATA, tx);
                apb(1'b1, SME_OFF_CMD, 32'h1);
                waitDone();
                `CHK("word out", msk(tx, width), slv.got[0]);
                apb(1'b0, SME_OFF_RXDATA, 32'h0);
                `CHK("word in", msk(slv.rsp[0], width), rdat);
                csN = 1'b1;
            end
        end
        openCh(0, 0);
        apb(1'b1, SME_OFF_CMD, 32'h00010028);
        apb(1'b1, SME_OFF_CMD, 32'h1);
        `CHK("cmd busy", 1'b1, rerr);
        apb(1'b1, SME_OFF_SPEED, 32'h00000001);
        `CHK("speed busy", 1'b1, rerr);
        apb(1'b1, SME_OFF_RXDATA, 32'h0);
        `CHK("rx write", 1'b1, rerr);
        apb(1'b1, SME_OFF_CTRL, 32'h0);
        `CHK("close busy", 1'b1, rerr);
        for (int i = 0; i < 40; i++) begin
            txq.push_back(32'($random(seed)) & 32'hFF);
            apb(1'b1, SME_OFF_TXDATA, txq[i]);
        end
        apb(1'b0, SME_OFF_STATUS, 32'h0);
        `CHK("tx full", 32, rdat[13:8]);
        waitDone();
        for (int i = 0; i < 40; i++) `CHK("bulk out", txq[i], slv.got[i]);
        apb(1'b0, SME_OFF_STATUS, 32'h0);
        `CHK("levels", 32'h0, {rdat[21:16], rdat[13:8]});
        apb(1'b0, SME_OFF_RXDATA, 32'h0);
        `CHK("rx empty", 1'b1, rerr);
        csN = 1'b1;
        openCh(3, 1);
        for (int i = 0; i < 4; i++) slv.rsp[i] = $random(seed);
        apb(1'b1, SME_OFF_CMD, 32'h00020004);
        waitDone();
        for (int i = 0; i < 4; i++) begin
            `CHK("zeros out", 32'h0, slv.got[i]);
            apb(1'b0, SME_OFF_RXDATA, 32'h0);
            `CHK("bulk in", msk(slv.rsp[i], 16), rdat);
        end
        csN = 1'b1;
        apb(1'b1, SME_OFF_CTRL, 32'h0);
        @(negedge clk);
        `CHK("closed", 3'b000, {sclkOe, mosiOe, mosi});
        results();
    end
    // whole run needs about 8000 cycles
    initial begin
        repeat (60000) @(posedge clk);
        err_total++;
        results();
    end
endmodule
`default_nettype wire
